// ### fbm_map.vh
// Constants of the flash block manager
`ifndef FBM_MAP_VH
`define FBM_MAP_VH

// ----------------------------------------
// Sizes of the mapped store
// ----------------------------------------
`define FBM_LBA_W     22
`define FBM_LOG_W     6
`define FBM_LOG_N     64
`define FBM_PHY_W     7
`define FBM_PHY_TOT   8'h80
`define FBM_PHY_N     8'h78
`define FBM_SPARE_N   4'h8
`define FBM_SPARE_W   4
`define FBM_DATA_W    16
`define FBM_CODE_W    22
`define FBM_SYN_W     5

// ----------------------------------------
// Flash operation codes
// ----------------------------------------
`define FBM_OP_READ   1'h0
`define FBM_OP_PROG   1'h1

// ----------------------------------------
// Geometry: cylinders, heads, sectors, total
// ----------------------------------------
`define FBM_GEO_W     45
`define FBM_GEO_16M   {12'h3E8, 5'h02, 6'h10, 22'h00_7D00}
`define FBM_GEO_32M   {12'h1F4, 5'h08, 6'h10, 22'h00_FA00}
`define FBM_GEO_64M   {12'h1F4, 5'h08, 6'h20, 22'h01_F400}
`define FBM_GEO_128M  {12'h1F4, 5'h10, 6'h20, 22'h03_E800}
`define FBM_GEO_192M  {12'h2EE, 5'h10, 6'h20, 22'h05_DC00}
`define FBM_GEO_256M  {12'h3E8, 5'h10, 6'h20, 22'h07_D000}
`define FBM_GEO_512M  {12'h3F7, 5'h10, 6'h3F, 22'h0F_9C90}
`define FBM_GEO_1024M {12'h7EF, 5'h10, 6'h3F, 22'h1F_3D10}
`define FBM_GEO_1536M {12'hBE7, 5'h10, 6'h3F, 22'h2E_DD90}
`define FBM_GEO_NONE  45'h0000_0000_0000

`endif

// ### fbm_ecc.v
// Single-error-correct, double-error-detect code over one data word
`timescale 1ns/1ns
`default_nettype none
`include "fbm_map.vh"

module fbm_ecc (
   input  wire [`FBM_DATA_W-1:0] enc_data,
   output reg  [`FBM_CODE_W-1:0] enc_code,
   input  wire [`FBM_CODE_W-1:0] dec_code,
   output reg  [`FBM_DATA_W-1:0] dec_data,
   output reg                    dec_single,
   output reg                    dec_double
);
   // Bit 0 is overall parity, positions 1..21 form a Hamming code
   // Each process keeps its own loop indices so neither wakes the other
   integer                  j;
   integer                  k;
   integer                  m;
   integer                  n;
   reg [`FBM_SYN_W-1:0]     syn;
   reg [`FBM_CODE_W-1:0]    fix;
   reg                      par;

   // ----------------------------------------
   // Encoder
   // ----------------------------------------
   always @* begin
      enc_code = {`FBM_CODE_W{1'b0}};
      k = 0;
      for (j = 1; j < `FBM_CODE_W; j = j + 1) begin
         if ((j & (j - 1)) != 0) begin
            enc_code[j] = enc_data[k];
            k = k + 1;
         end
      end
      for (j = 1; j < `FBM_CODE_W; j = j + 1) begin
         if ((j & (j - 1)) != 0 && enc_code[j]) begin
            for (k = 0; k < `FBM_SYN_W; k = k + 1) begin
               if (j[k])
                  enc_code[1 << k] = ~enc_code[1 << k];
            end
         end
      end
      enc_code[0] = ^enc_code[`FBM_CODE_W-1:1];
   end

   // ----------------------------------------
   // Decoder
   // ----------------------------------------
   always @* begin
      syn = {`FBM_SYN_W{1'b0}};
      for (m = 1; m < `FBM_CODE_W; m = m + 1) begin
         if (dec_code[m])
            syn = syn ^ m[`FBM_SYN_W-1:0];
      end
      par = ^dec_code;
      fix = dec_code;
      dec_single = par;
      dec_double = !par && (syn != {`FBM_SYN_W{1'b0}});
      // A syndrome beyond the word is a multi-bit error; no flip
      if (par && syn != {`FBM_SYN_W{1'b0}} && syn < `FBM_CODE_W)
         fix[syn] = ~fix[syn];
      dec_data = {`FBM_DATA_W{1'b0}};
      n = 0;
      for (m = 1; m < `FBM_CODE_W; m = m + 1) begin
         if ((m & (m - 1)) != 0) begin
            dec_data[n] = fix[m];
            n = n + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ### fbm_manager.v
// Flash block manager: address mapping, wear spreading, spares, lock, ECC
`timescale 1ns/1ns
`default_nettype none
`include "fbm_map.vh"

module fbm_manager (
   input  wire                       clk,
   input  wire                       nrst,
   input  wire [3:0]                 cap_sel,
   output reg  [11:0]                geo_cyl,
   output reg  [4:0]                 geo_head,
   output reg  [5:0]                 geo_spt,
   output reg  [`FBM_LBA_W-1:0]      geo_total,
   input  wire                       req_valid,
   output wire                       req_ready,
   input  wire                       req_write,
   input  wire [`FBM_LBA_W-1:0]      req_lba,
   input  wire [`FBM_DATA_W-1:0]     req_wdata,
   output reg                        rsp_valid,
   output reg  [`FBM_DATA_W-1:0]     rsp_rdata,
   output reg                        rsp_err,
   output reg                        rsp_uncorr,
   output reg                        locked,
   output reg  [`FBM_SPARE_W-1:0]    spares_left,
   output reg                        fl_valid,
   input  wire                       fl_ready,
   output reg                        fl_op,
   output reg  [`FBM_PHY_W-1:0]      fl_addr,
   output reg  [`FBM_CODE_W-1:0]     fl_wcode,
   input  wire                       fl_done,
   input  wire                       fl_fail,
   input  wire [`FBM_CODE_W-1:0]     fl_rcode
);
   localparam [5:0] ST_IDLE  = 6'h01;
   localparam [5:0] ST_FIND  = 6'h02;
   localparam [5:0] ST_ISSUE = 6'h04;
   localparam [5:0] ST_PWAIT = 6'h08;
   localparam [5:0] ST_RWAIT = 6'h10;
   localparam [5:0] ST_DONE  = 6'h20;

   reg  [5:0]                  state;
   reg  [`FBM_PHY_W-1:0]       map_phys [0:`FBM_LOG_N-1];
   reg  [`FBM_LOG_N-1:0]       map_ok;
   reg  [`FBM_PHY_TOT-1:0]     used;
   reg  [`FBM_PHY_W-1:0]       scan;
   reg  [7:0]                  scan_cnt;
   reg  [`FBM_SPARE_W-1:0]     spare_used;
   reg  [`FBM_LOG_W-1:0]       cur_log;
   reg  [`FBM_DATA_W-1:0]      cur_data;
   reg  [`FBM_PHY_W-1:0]       alloc;
   reg                         d_err;
   reg                         d_uncorr;
   reg  [`FBM_DATA_W-1:0]      d_data;
   wire [`FBM_CODE_W-1:0]      enc_code;
   wire [`FBM_DATA_W-1:0]      dec_data;
   wire                        dec_double;
   wire [`FBM_GEO_W-1:0]       geo;
   wire                        in_range;
   wire [`FBM_LOG_W-1:0]       req_log;
   wire [7:0]                  pool_lim;
   wire                        scan_free;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [`FBM_GEO_W-1:0] geo_of;
      input [3:0] sel;
      begin
         case (sel)
            4'h0:    geo_of = `FBM_GEO_16M;
            4'h1:    geo_of = `FBM_GEO_32M;
            4'h2:    geo_of = `FBM_GEO_64M;
            4'h3:    geo_of = `FBM_GEO_128M;
            4'h4:    geo_of = `FBM_GEO_192M;
            4'h5:    geo_of = `FBM_GEO_256M;
            4'h6:    geo_of = `FBM_GEO_512M;
            4'h7:    geo_of = `FBM_GEO_1024M;
            4'h8:    geo_of = `FBM_GEO_1536M;
            default: geo_of = `FBM_GEO_NONE;
         endcase
      end
   endfunction

   // Spare locations sit above the ordinary pool; each replacement
   // widens the searchable range by one
   function [7:0] lim_of;
      input [`FBM_SPARE_W-1:0] n;
      begin
         lim_of = `FBM_PHY_N + {4'h0, n};
      end
   endfunction

   assign geo       = geo_of(cap_sel);
   assign req_log   = req_lba[`FBM_LOG_W-1:0];
   assign in_range  = (req_lba < `FBM_LOG_N);
   assign pool_lim  = lim_of(spare_used);
   assign scan_free = !used[scan] && ({1'b0, scan} < pool_lim);
   assign req_ready = (state == ST_IDLE);

   fbm_ecc u_ecc (
      .enc_data   (cur_data),
      .enc_code   (enc_code),
      .dec_code   (fl_rcode),
      .dec_data   (dec_data),
      .dec_single (),
      .dec_double (dec_double)
   );

   // ----------------------------------------
   // Geometry
   // ----------------------------------------
   // Capacity strap is sampled every clock, never under reset
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         geo_cyl   <= 12'h000;
         geo_head  <= 5'h00;
         geo_spt   <= 6'h00;
         geo_total <= 22'h00_0000;
      end else begin
         {geo_cyl, geo_head, geo_spt, geo_total} <= geo;
      end
   end

   // ----------------------------------------
   // Mapping table contents carry no reset; map_ok qualifies them
   // ----------------------------------------
   always @(posedge clk) begin
      if (state == ST_PWAIT && fl_done && !fl_fail)
         map_phys[cur_log] <= alloc;
   end

   // ----------------------------------------
   // Control
   // ----------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state       <= ST_IDLE;
         map_ok      <= {`FBM_LOG_N{1'b0}};
         used        <= {`FBM_PHY_TOT{1'b0}};
         scan        <= {`FBM_PHY_W{1'b0}};
         scan_cnt    <= 8'h00;
         spare_used  <= {`FBM_SPARE_W{1'b0}};
         spares_left <= `FBM_SPARE_N;
         locked      <= 1'b0;
         cur_log     <= {`FBM_LOG_W{1'b0}};
         cur_data    <= {`FBM_DATA_W{1'b0}};
         alloc       <= {`FBM_PHY_W{1'b0}};
         d_err       <= 1'b0;
         d_uncorr    <= 1'b0;
         d_data      <= {`FBM_DATA_W{1'b0}};
         fl_valid    <= 1'b0;
         fl_op       <= `FBM_OP_READ;
         fl_addr     <= {`FBM_PHY_W{1'b0}};
         fl_wcode    <= {`FBM_CODE_W{1'b0}};
         rsp_valid   <= 1'b0;
         rsp_rdata   <= {`FBM_DATA_W{1'b0}};
         rsp_err     <= 1'b0;
         rsp_uncorr  <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         case (state)
            ST_IDLE: begin
               d_err    <= 1'b0;
               d_uncorr <= 1'b0;
               d_data   <= {`FBM_DATA_W{1'b0}};
               cur_log  <= req_log;
               cur_data <= req_wdata;
               scan_cnt <= 8'h00;
               if (req_valid) begin
                  if (!in_range) begin
                     d_err <= 1'b1;
                     state <= ST_DONE;
                  end else if (req_write && locked) begin
                     d_err <= 1'b1;
                     state <= ST_DONE;
                  end else if (req_write) begin
                     state <= ST_FIND;
                  end else if (map_ok[req_log]) begin
                     // Reads stay open in the locked state for backup
                     fl_valid <= 1'b1;
                     fl_op    <= `FBM_OP_READ;
                     fl_addr  <= map_phys[req_log];
                     state    <= ST_ISSUE;
                  end else begin
                     state <= ST_DONE;
                  end
               end
            end
            ST_FIND: begin
               // Rotating scan keeps rewrites of one address moving
               if (scan_free) begin
                  used     <= used | ({{(`FBM_PHY_TOT-1){1'b0}}, 1'b1} << scan);
                  alloc    <= scan;
                  fl_valid <= 1'b1;
                  fl_op    <= `FBM_OP_PROG;
                  fl_addr  <= scan;
                  fl_wcode <= enc_code;
                  state    <= ST_ISSUE;
               end else if (scan_cnt == `FBM_PHY_TOT - 8'h01) begin
                  d_err <= 1'b1;
                  state <= ST_DONE;
               end
               scan     <= scan + {{(`FBM_PHY_W-1){1'b0}}, 1'b1};
               scan_cnt <= scan_cnt + 8'h01;
            end
            ST_ISSUE: begin
               if (fl_ready) begin
                  fl_valid <= 1'b0;
                  state    <= (fl_op == `FBM_OP_PROG) ? ST_PWAIT : ST_RWAIT;
               end
            end
            ST_PWAIT: begin
               if (fl_done) begin
                  if (!fl_fail) begin
                     // Old copy is released only after the new one holds
                     if (map_ok[cur_log])
                        used <= used & ~({{(`FBM_PHY_TOT-1){1'b0}}, 1'b1}
                                         << map_phys[cur_log]);
                     map_ok[cur_log] <= 1'b1;
                     state           <= ST_DONE;
                  end else if (spare_used != `FBM_SPARE_N) begin
                     // Failed block stays marked used: it is retired for good
                     // Next spare sits exactly at the current pool limit
                     alloc       <= pool_lim[`FBM_PHY_W-1:0];
                     used        <= used | ({{(`FBM_PHY_TOT-1){1'b0}}, 1'b1}
                                            << pool_lim);
                     fl_valid    <= 1'b1;
                     fl_addr     <= pool_lim[`FBM_PHY_W-1:0];
                     spare_used  <= spare_used + {{(`FBM_SPARE_W-1){1'b0}}, 1'b1};
                     spares_left <= spares_left - {{(`FBM_SPARE_W-1){1'b0}}, 1'b1};
                     // The last replacement still finishes its copy
                     if (spare_used == `FBM_SPARE_N - 4'h1)
                        locked <= 1'b1;
                     state <= ST_ISSUE;
                  end else begin
                     locked <= 1'b1;
                     d_err  <= 1'b1;
                     state  <= ST_DONE;
                  end
               end
            end
            ST_RWAIT: begin
               if (fl_done) begin
                  d_data   <= dec_data;
                  d_uncorr <= dec_double;
                  state    <= ST_DONE;
               end
            end
            ST_DONE: begin
               rsp_valid  <= 1'b1;
               rsp_rdata  <= d_data;
               rsp_err    <= d_err;
               rsp_uncorr <= d_uncorr;
               state      <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### fbm_manager_assertions.sv
// Concurrent checks on the ports of the flash block manager
`timescale 1ns/1ns
`default_nettype none
module fbm_manager_assertions (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [3:0]  cap_sel,
   input wire logic [11:0] geo_cyl,
   input wire logic [4:0]  geo_head,
   input wire logic [5:0]  geo_spt,
   input wire logic [21:0] geo_total,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic        req_write,
   input wire logic [21:0] req_lba,
   input wire logic        rsp_valid,
   input wire logic        rsp_err,
   input wire logic        locked,
   input wire logic [3:0]  spares_left,
   input wire logic        fl_valid,
   input wire logic        fl_ready,
   input wire logic        fl_op,
   input wire logic [6:0]  fl_addr,
   input wire logic        fl_done,
   input wire logic        fl_fail
);
   // ----------------------------------------
   // Last programmed location
   // ----------------------------------------
   // Top spare is the reset value: it is only ever used after every pool write is done
   logic [6:0] last_addr;
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         last_addr <= 7'h7F;
      else if (fl_valid && fl_ready && fl_op)
         last_addr <= fl_addr;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_geo_512; $past(nrst) && $past(cap_sel) == 4'h6 |-> geo_cyl == 12'h3F7
      && geo_head == 5'h10 && geo_spt == 6'h3F && geo_total == 22'h0F_9C90; endproperty
   a_geo_512: assert property (p_geo_512) else $error("wrong geometry");
   property p_spare_idle; fl_valid && fl_op && fl_addr >= 7'h78 |-> ##[0:1] spares_left < 4'h8;
   endproperty
   a_spare_idle: assert property (p_spare_idle) else $error("spare used early");
   property p_spare_swap; fl_done && fl_fail && spares_left != 4'h0
      |-> ##[1:3] (fl_valid && fl_op && fl_addr >= 7'h78); endproperty
   a_spare_swap: assert property (p_spare_swap) else $error("no spare copy");
   property p_lock_spent; locked |-> spares_left == 4'h0; endproperty
   a_lock_spent: assert property (p_lock_spent) else $error("lock with spares");
   property p_lock_enter; spares_left == 4'h0 |-> ##[0:2] locked; endproperty
   a_lock_enter: assert property (p_lock_enter) else $error("no lock");
   property p_lock_quiet; locked && $past(locked, 8) |-> !(fl_valid && fl_op); endproperty
   a_lock_quiet: assert property (p_lock_quiet) else $error("program while locked");
   property p_lock_reject; locked && req_valid && req_ready && req_write
      |-> !fl_valid ##1 !fl_valid ##1 (rsp_valid && rsp_err); endproperty
   a_lock_reject: assert property (p_lock_reject) else $error("locked write taken");
   property p_lock_read; locked && req_valid && req_ready && !req_write
      && req_lba < 22'h00_0040 |-> ##[2:20] (rsp_valid && !rsp_err); endproperty
   a_lock_read: assert property (p_lock_read) else $error("locked read lost");
   property p_new_place; fl_valid && fl_ready && fl_op |-> fl_addr != last_addr; endproperty
   a_new_place: assert property (p_new_place) else $error("same place");
endmodule
bind fbm_manager fbm_manager_assertions u_fbm_manager_assertions (
   .clk(clk), .nrst(nrst), .cap_sel(cap_sel), .geo_cyl(geo_cyl), .geo_head(geo_head),
   .geo_spt(geo_spt), .geo_total(geo_total), .req_valid(req_valid), .req_ready(req_ready),
   .req_write(req_write), .req_lba(req_lba), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
   .locked(locked), .spares_left(spares_left), .fl_valid(fl_valid), .fl_ready(fl_ready),
   .fl_op(fl_op), .fl_addr(fl_addr), .fl_done(fl_done), .fl_fail(fl_fail));
`default_nettype wire

// ### fbm_flash_model.sv
// Behavioural flash array on the far side of the flash port
`timescale 1ns/1ns
`default_nettype none
module fbm_flash_model (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        fl_valid,
   output wire logic        fl_ready,
   input  wire logic        fl_op,
   input  wire logic [6:0]  fl_addr,
   input  wire logic [21:0] fl_wcode,
   output var  logic        fl_done,
   output var  logic        fl_fail,
   output var  logic [21:0] fl_rcode,
   input  wire logic        fail_pool,
   input  wire logic [21:0] flip
);
   logic [21:0] mem [0:127];
   logic        busy, op;
   logic [6:0]  addr;
   logic [21:0] code;
   logic [1:0]  wait_n;
   logic [31:0] rnd;
   integer      seed = 32'h3877_7645;
   assign fl_ready = !busy;
   // ----------------------------------------
   // Operation engine
   // ----------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy <= 1'b0;
         fl_done <= 1'b0;
         fl_fail <= 1'b0;
         fl_rcode <= 22'h00_0000;
      end else begin
         rnd = $random(seed);
         fl_done <= 1'b0;
         fl_fail <= 1'b0;
         // Read data never stands still outside an answer
         fl_rcode <= ~fl_rcode;
         if (fl_valid && !busy) begin
            busy <= 1'b1;
            op <= fl_op;
            addr <= fl_addr;
            code <= fl_wcode;
            wait_n <= rnd[1:0];
         end else if (busy && wait_n != 2'h0) begin
            wait_n <= wait_n - 2'h1;
         end else if (busy) begin
            busy <= 1'b0;
            fl_done <= 1'b1;
            if (!op)
               fl_rcode <= mem[addr] ^ flip;
            else if (fail_pool && addr < 7'h78)
               fl_fail <= 1'b1;
            else
               mem[addr] <= code;
         end
      end
   end
endmodule
`default_nettype wire

// ### fbm_manager_bench.sv
// Self-checking bench of the flash block manager
`timescale 1ns/1ns
`default_nettype none
module fbm_manager_bench;
   logic        clk, nrst, req_valid, req_write, fail_pool, got_err, got_unc;
   logic [3:0]  cap_sel;
   logic [21:0] req_lba, flip;
   logic [15:0] req_wdata, got;
   logic [15:0] ref_data [0:63];
   logic [6:0]  loc [0:63];
   logic [63:0] written;
   logic [6:0]  last_prog;
   wire  [11:0] geo_cyl;
   wire  [4:0]  geo_head;
   wire  [5:0]  geo_spt;
   wire  [21:0] geo_total, fl_wcode, fl_rcode;
   wire  [15:0] rsp_rdata;
   wire  [6:0]  fl_addr;
   wire  [3:0]  spares_left;
   wire         req_ready, rsp_valid, rsp_err, rsp_uncorr, locked;
   wire         fl_valid, fl_ready, fl_op, fl_done, fl_fail;
   integer      seed, fails, n_compared, i, a;
   fbm_manager u_fbm_manager (.clk(clk), .nrst(nrst), .cap_sel(cap_sel), .geo_cyl(geo_cyl),
      .geo_head(geo_head), .geo_spt(geo_spt), .geo_total(geo_total), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_lba(req_lba), .req_wdata(req_wdata),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .rsp_uncorr(rsp_uncorr),
      .locked(locked), .spares_left(spares_left), .fl_valid(fl_valid), .fl_ready(fl_ready),
      .fl_op(fl_op), .fl_addr(fl_addr), .fl_wcode(fl_wcode), .fl_done(fl_done),
      .fl_fail(fl_fail), .fl_rcode(fl_rcode));
   fbm_flash_model u_fbm_flash_model (.clk(clk), .nrst(nrst), .fl_valid(fl_valid),
      .fl_ready(fl_ready), .fl_op(fl_op), .fl_addr(fl_addr), .fl_wcode(fl_wcode),
      .fl_done(fl_done), .fl_fail(fl_fail), .fl_rcode(fl_rcode), .fail_pool(fail_pool),
      .flip(flip));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) if (fl_valid && fl_ready && fl_op) last_prog <= fl_addr;
   function logic [44:0] geo_of(input logic [3:0] s);
      case (s)
         4'h0: geo_of = {12'h3E8, 5'h02, 6'h10, 22'h00_7D00};
         4'h1: geo_of = {12'h1F4, 5'h08, 6'h10, 22'h00_FA00};
         4'h2: geo_of = {12'h1F4, 5'h08, 6'h20, 22'h01_F400};
         4'h3: geo_of = {12'h1F4, 5'h10, 6'h20, 22'h03_E800};
         4'h4: geo_of = {12'h2EE, 5'h10, 6'h20, 22'h05_DC00};
         4'h5: geo_of = {12'h3E8, 5'h10, 6'h20, 22'h07_D000};
         4'h6: geo_of = {12'h3F7, 5'h10, 6'h3F, 22'h0F_9C90};
         4'h7: geo_of = {12'h7EF, 5'h10, 6'h3F, 22'h1F_3D10};
         4'h8: geo_of = {12'hBE7, 5'h10, 6'h3F, 22'h2E_DD90};
         default: geo_of = 45'h0000_0000_0000;
      endcase
   endfunction
   // ----------------------------------------
   // Host request tasks
   // ----------------------------------------
   task chk(input logic ok, input string what);
      begin
         n_compared = n_compared + 1;
         if (!ok) begin
            fails = fails + 1;
            $display("[ERR] %0t %s", $time, what);
         end
      end
   endtask
   // Ready only changes on rising edges, so it is looked at on the falling one
   task xfer(input logic w, input logic [21:0] lba, input logic [15:0] d);
      integer n;
      begin
         n = 0;
         @(posedge clk);
         req_valid <= 1'b1;
         req_write <= w;
         req_lba <= lba;
         req_wdata <= d;
         @(negedge clk);
         while (req_ready !== 1'b1 && n < 300) begin
            @(negedge clk);
            n = n + 1;
         end
         @(posedge clk);
         req_valid <= 1'b0;
         @(negedge clk);
         while (rsp_valid !== 1'b1 && n < 300) begin
            @(negedge clk);
            n = n + 1;
         end
         chk(n < 300, "no answer");
         got = rsp_rdata;
         got_err = rsp_err;
         got_unc = rsp_uncorr;
      end
   endtask
   task wr(input integer a, input logic [15:0] d);
      begin
         xfer(1'b1, a[21:0], d);
         chk(got_err === 1'b0, "write refused");
         if (written[a]) chk(last_prog !== loc[a], "rewrite in place");
         loc[a] = last_prog;
         ref_data[a] = d;
         written[a] = 1'b1;
      end
   endtask
   task rd(input integer a);
      begin
         xfer(1'b0, a[21:0], 16'h0000);
         chk(got === ref_data[a] && got_err === 1'b0 && got_unc === 1'b0, "read data");
      end
   endtask
   task give_verdict;
      begin
         $display("compared %0d failed %0d", n_compared, fails);
         if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   initial begin
      #(40 * 30000);
      fails = fails + 1;
      give_verdict;
   end
   initial begin
      seed = 32'h3877_7645;
      {fails, n_compared, written, flip} = 0;
      {nrst, req_valid, req_write, req_lba, req_wdata, cap_sel, fail_pool} = 0;
      for (i = 0; i < 64; i++) ref_data[i] = 16'h0000;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge clk);
         cap_sel <= i[3:0];
         @(posedge clk);
         @(negedge clk);
         chk({geo_cyl, geo_head, geo_spt, geo_total} === geo_of(i[3:0]), "geometry");
      end
      cap_sel <= 4'($random(seed));
      for (i = 0; i < 40; i++) begin
         a = (i < 16) ? i % 3 : $random(seed) & 63;
         wr(a, 16'($random(seed)));
      end
      for (i = 0; i < 64; i++) rd(i);
      xfer(1'b1, 22'h00_0040 | 22'($random(seed)), 16'h0000);
      chk(got_err === 1'b1, "range not refused");
      for (i = 0; i < 22; i++) begin
         flip = 22'h00_0001 << i;
         rd(0);
      end
      for (i = 0; i < 21; i++) begin
         flip = 22'h00_0003 << i;
         xfer(1'b0, 22'h00_0000, 16'h0000);
         chk(got_unc === 1'b1, "double error missed");
      end
      flip = 22'h00_0000;
      fail_pool = 1'b1;
      for (i = 0; i < 8; i++) begin
         wr(1, 16'($random(seed)));
         chk(spares_left === 4'(7 - i), "spare count");
         rd(1);
      end
      chk(locked === 1'b1, "not locked");
      xfer(1'b1, 22'h00_0002, 16'hA5A5);
      chk(got_err === 1'b1, "locked write taken");
      for (i = 0; i < 64; i++) rd(i);
      give_verdict;
   end
endmodule
`default_nettype wire
